// [src/rsm_pkg.sv]
/*
  Constants for the receive statistics interrupt mask block: register offsets,
  field layout, reset values and counter event bit positions.
  Assumes a 12-bit byte address on a plain strobe register port.
*/
package rsm_pkg;
  // Register byte offsets
  localparam logic [11:0] RSM_OFS_MASK = 12'h10C;
  localparam logic [11:0] RSM_OFS_STAT = 12'h104;
  // Layout
  localparam int RSM_NBITS = 24;
  localparam logic [31:0] RSM_MASK_RESET = 32'h0000_0000;
  localparam logic [23:0] RSM_STAT_RESET = 24'h00_0000;
  localparam logic [7:0] RSM_RSVD_VAL = 8'h00;
  // Counter thresholds that raise an event
  localparam logic [31:0] RSM_HALF32 = 32'h8000_0000;
  localparam logic [15:0] RSM_HALF16 = 16'h8000;
  // Event bit positions
  localparam int RSM_B_WDOG = 23;
  localparam int RSM_B_TAGGED = 22;
  localparam int RSM_B_OVERRUN = 21;
  localparam int RSM_B_PAUSE = 20;
  localparam int RSM_B_TYPE_OOR = 19;
  localparam int RSM_B_LEN_ERR = 18;
  localparam int RSM_B_SINGLE = 17;
  localparam int RSM_B_HIST5 = 16;
  localparam int RSM_B_HIST0 = 11;
  localparam int RSM_B_OVERSIZE = 10;
  localparam int RSM_B_UNDERSIZE = 9;
  localparam int RSM_B_JABBER = 8;
  localparam int RSM_B_RUNT = 7;
  localparam int RSM_B_ALIGN = 6;
  localparam int RSM_B_CRC = 5;
  localparam int RSM_B_MCAST = 4;
  localparam int RSM_B_BCAST = 3;
endpackage : rsm_pkg

// [src/rsm_stat_bit.sv]
/*
  One sticky counter interrupt status bit.
  Assumes event and clear inputs are one-cycle pulses synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rsm_stat_bit
  import rsm_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Events and clear
  input wire logic i_half,
  input wire logic i_full,
  input wire logic i_clr,
  // Flag
  output logic o_flag
);
  typedef struct packed {
    logic flag;
  } rsm_bit_state_type;

  rsm_bit_state_type state;
  rsm_bit_state_type next_state;

  // Set wins over clear so an event in the clearing cycle is not lost
  always_comb begin
    next_state = state;
    if (i_clr) begin
      next_state.flag = 1'b0;
    end
    if (i_half || i_full) begin
      next_state.flag = 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= '{flag: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign o_flag = state.flag;
endmodule : rsm_stat_bit
`default_nettype wire

// [src/rsm_irq_mask.sv]
/*
  Receive statistics counter interrupt mask and status bank.
  Holds the mask register, the sticky status bits and the combined interrupt.
  Assumes the counters outside give one-cycle half and full range pulses and a
  pulse when software reads the low byte of each counter.
*/
// Decided for this implementation: the strobed register port.
// Summary of operation
// - Set mask bit blocks half and full events
// - One 32-bit mask register at 010Ch
// - Bits 23..20: watchdog, tagged, overrun, pause
// - Bit 19 type out of range, 18 length
// - Bit 17 governs single destination frames
// - Bits 16..11 govern length histogram bins
// - Bits 10..7: oversize, undersize, jabber, runt
// - Bit 6 alignment, bit 5 CRC errors
// - Bit 4 multicast, bit 3 broadcast
// - Events at half range and at all ones
// - Status clears on counter low byte read; a status read also clears all flags
`timescale 1ns/1ps
`default_nettype none
module rsm_irq_mask
  import rsm_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Counter events, one pulse per crossing
  input wire logic [23:0] i_cnt_half,
  input wire logic [23:0] i_cnt_full,
  // Pulse when the low byte of a counter is read
  input wire logic [23:0] i_cnt_lsb_rd,
  // Combined interrupt and mask
  output logic o_irq,
  output logic [23:0] o_irq_mask
);
  typedef struct packed {
    logic [23:0] mask;
    logic [31:0] rdata;
    logic irq;
  } rsm_state_type;

  rsm_state_type state;
  rsm_state_type next_state;
  logic [23:0] status;
  logic [23:0] stat_clr;

  // Shared address decode
  function automatic logic rsm_hit(input logic [11:0] addr, input logic [11:0] ofs);
    rsm_hit = (addr == ofs);
  endfunction : rsm_hit

  // Status clears on a low byte read of its counter or on a status read.
  // The status read path is a convenience for software that polls the bank
  // instead of walking every counter; it clears all flags at once, so a
  // driver that wants per counter clearing must only read the counters.
  // Status clears on a low byte read of its counter or on a status read
  assign stat_clr = i_cnt_lsb_rd | {RSM_NBITS{i_rd && rsm_hit(i_addr, RSM_OFS_STAT)}};

  // One sticky bit per counter; a half or full crossing sets it
  genvar gi;
  generate
    for (gi = 0; gi < RSM_NBITS; gi++) begin : g_stat
      rsm_stat_bit u_bit (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_half(i_cnt_half[gi]),
        .i_full(i_cnt_full[gi]),
        .i_clr(stat_clr[gi]),
        .o_flag(status[gi])
      );
    end
  endgenerate

  // Mask bit map, one counter per bit; bits 2..0 serve the three lower
  // counters and behave exactly like the bits above them
  // Bit 23 receive watchdog errors
  // Bit 22 tagged frames, good and bad
  // Bit 21 receive buffer overruns
  // Bit 20 pause frames received
  // Bit 19 frames with type out of range
  // Bit 18 length errors
  // Bit 17 single destination frames
  // Bit 16 length histogram bin 5, 1024 to maximum
  // Bit 15 length histogram bin 4, 512 to 1023
  // Bit 14 length histogram bin 3, 256 to 511
  // Bit 13 length histogram bin 2, 128 to 255
  // Bit 12 length histogram bin 1, 65 to 127
  // Bit 11 length histogram bin 0, 64 octets
  // Bit 10 oversize good frames
  // Bit 9 undersize good frames
  // Bit 8 jabber errors
  // Bit 7 runt errors
  // Bit 6 alignment errors
  // Bit 5 CRC errors
  // Bit 4 good multicast frames
  // Bit 3 good broadcast frames
  // The bank is uniform, so bit position alone routes each counter;
  // the counters outside must wire their pulses to these positions.

  // Register writes, read data and interrupt combine.
  // The interrupt is registered so software never sees a glitch, at the
  // cost of one cycle of latency behind the status and mask.
  always_comb begin
    next_state = state;
    if (i_wr && rsm_hit(i_addr, RSM_OFS_MASK)) begin
      next_state.mask = i_wdata[23:0];
    end
    // Read data stands only in the cycle after the strobe
    next_state.rdata = 32'h0000_0000;
    if (i_rd) begin
      if (rsm_hit(i_addr, RSM_OFS_MASK)) begin
        next_state.rdata = {RSM_RSVD_VAL, state.mask};
      end else if (rsm_hit(i_addr, RSM_OFS_STAT)) begin
        next_state.rdata = {RSM_RSVD_VAL, status};
      end
    end
    // Registered, so it trails the status by one cycle but never glitches
    next_state.irq = |(status & ~state.mask);
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= '{mask: RSM_MASK_RESET[23:0], rdata: 32'h0000_0000, irq: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign o_rdata = state.rdata;
  assign o_irq = state.irq;
  assign o_irq_mask = state.mask;

  // Checks
  a_mask_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == RSM_OFS_MASK) |=> (o_irq_mask == $past(i_wdata[23:0])))
    else $error("mask write not stored");
  a_mask_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_rd && i_addr == RSM_OFS_MASK) |=> (o_rdata == {8'h00, $past(o_irq_mask)}))
    else $error("mask read data wrong");
  a_rsvd_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    o_rdata[31:24] == 8'h00)
    else $error("reserved bits not zero");
  a_irq_combine: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ##1 (o_irq == $past(|(status & ~o_irq_mask))))
    else $error("interrupt does not follow unmasked status");
  a_event_sets: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (|(i_cnt_half | i_cnt_full)) |=> ((status & $past(i_cnt_half | i_cnt_full)) == $past(i_cnt_half | i_cnt_full)))
    else $error("counter event did not set status");
  a_lsb_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_cnt_lsb_rd[RSM_B_CRC] && !i_cnt_half[RSM_B_CRC] && !i_cnt_full[RSM_B_CRC]) |=> !status[RSM_B_CRC])
    else $error("low byte read did not clear status");
  a_hold_status: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (status[RSM_B_JABBER] && !stat_clr[RSM_B_JABBER]) |=> status[RSM_B_JABBER])
    else $error("status lost without a read");
  a_wdog_block: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ((status & ~24'hFE_0000) == 24'h00_0000 && (&o_irq_mask[RSM_B_WDOG:RSM_B_SINGLE])) |=> !o_irq)
    else $error("masked upper events still interrupt");
  a_hist_block: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ((status & ~24'h01_FF80) == 24'h00_0000 && (&o_irq_mask[RSM_B_HIST5:RSM_B_RUNT])) |=> !o_irq)
    else $error("masked histogram or size events still interrupt");
  a_err_block: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (status == 24'h00_0078 && !(|o_irq_mask[RSM_B_ALIGN:RSM_B_BCAST])) |=> o_irq)
    else $error("unmasked low events do not interrupt");
  // Read data return to zero when no read was made
  a_rdata_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !i_rd |=> (o_rdata == 32'h0000_0000))
    else $error("read data not idle");
  // A status read returns the flags as they stood at the strobe
  a_stat_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_rd && i_addr == RSM_OFS_STAT) |=> (o_rdata == {8'h00, $past(status)}))
    else $error("status read data wrong");
  // Unmapped reads return zero
  a_unmap_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_rd && i_addr != RSM_OFS_MASK && i_addr != RSM_OFS_STAT) |=> (o_rdata == 32'h0000_0000))
    else $error("unmapped read not zero");
  // The mask changes only by a write to its own offset
  a_mask_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    !(i_wr && i_addr == RSM_OFS_MASK) |=> $stable(o_irq_mask))
    else $error("mask changed without a write");
  // No unmasked flag means no interrupt
  a_irq_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ((status & ~o_irq_mask) == 24'h00_0000) |=> !o_irq)
    else $error("interrupt without an unmasked flag");
  // Writes to the status offset do not set flags
  a_stat_wr_ign: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (i_wr && i_addr == RSM_OFS_STAT && status == 24'h00_0000 && !(|(i_cnt_half | i_cnt_full))) |=>
    (status == 24'h00_0000))
    else $error("status write had an effect");

  // Per counter checks; each bit is one sticky flag behind one mask bit
  genvar gc;
  generate
    for (gc = 0; gc < RSM_NBITS; gc++) begin : g_chk
      // A half range crossing sets the flag
      a_half_sets: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_cnt_half[gc] |=> status[gc])
        else $error("half range event did not set its flag");
      // An all ones crossing sets the same flag
      a_full_sets: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_cnt_full[gc] |=> status[gc])
        else $error("all ones event did not set its flag");
      // An event in the clearing cycle is kept
      a_set_wins: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (stat_clr[gc] && (i_cnt_half[gc] || i_cnt_full[gc])) |=> status[gc])
        else $error("event lost in clearing cycle");
      // A clear with no event drops the flag
      a_bit_clears: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (stat_clr[gc] && !i_cnt_half[gc] && !i_cnt_full[gc]) |=> !status[gc])
        else $error("flag not cleared");
      // A flag never sets by itself
      a_bit_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (!status[gc] && !i_cnt_half[gc] && !i_cnt_full[gc]) |=> !status[gc])
        else $error("flag set without an event");
      // A flag stays set until cleared
      a_bit_holds: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (status[gc] && !stat_clr[gc]) |=> status[gc])
        else $error("flag dropped without a clear");
      // An unmasked flag raises the interrupt
      a_bit_unmasked: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (status[gc] && !o_irq_mask[gc]) |=> o_irq)
        else $error("unmasked flag did not interrupt");
      // A masked flag alone leaves the interrupt low
      a_bit_masked: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (status == (24'h00_0001 << gc) && o_irq_mask[gc]) |=> !o_irq)
        else $error("masked flag still interrupts");
      // Each mask bit takes its write data bit
      a_bit_mask_wr: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_wr && i_addr == RSM_OFS_MASK) |=> (o_irq_mask[gc] == $past(i_wdata[gc])))
        else $error("mask bit not written");
      // Each mask bit reads back in its own position
      a_bit_mask_rd: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_rd && i_addr == RSM_OFS_MASK) |=> (o_rdata[gc] == $past(o_irq_mask[gc])))
        else $error("mask bit read back wrong");
      // Each flag reads back in its own position
      a_bit_stat_rd: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_rd && i_addr == RSM_OFS_STAT) |=> (o_rdata[gc] == $past(status[gc])))
        else $error("flag read back wrong");
    end
  endgenerate
endmodule : rsm_irq_mask
`default_nettype wire

// [testbench/tb.sv]
/*
  Self-checking bench for the receive statistics interrupt mask bank.
  Assumes the plain strobe register port and one-cycle counter pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rsm_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [23:0] half = 24'h00_0000;
  logic [23:0] full = 24'h00_0000;
  logic [23:0] lsb = 24'h00_0000;
  logic [31:0] rdata;
  logic irq;
  logic [23:0] mask;
  logic [23:0] bit_n;
  int err_total = 0;
  int n_checks = 0;
  // Clock at 40 MHz
  always #12.5 clk = ~clk;
  rsm_irq_mask rsm_irq_mask_inst (.i_core_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cnt_half(half), .i_cnt_full(full),
    .i_cnt_lsb_rd(lsb), .o_irq(irq), .o_irq_mask(mask));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_reg
  task automatic pulse(input logic [23:0] h, input logic [23:0] f, input logic [23:0] c);
    @(posedge clk);
    half <= h;
    full <= f;
    lsb <= c;
    @(posedge clk);
    half <= 24'h00_0000;
    full <= 24'h00_0000;
    lsb <= 24'h00_0000;
  endtask : pulse
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  // Watchdog: the tests need well under 5000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(RSM_OFS_MASK, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr_reg(RSM_OFS_MASK, 32'hFFFF_FFFF);
    rd_reg(RSM_OFS_MASK, 32'h00FF_FFFF);
    chk({8'h00, mask}, 32'h00FF_FFFF);
    wr_reg(RSM_OFS_STAT, 32'hFFFF_FFFF);
    rd_reg(RSM_OFS_STAT, 32'h0000_0000);
    rd_reg(12'h200, 32'h0000_0000);
    $display("register access test done");
    // Each counter: masked, unmasked, cleared by low byte read and by status read
    for (int n = 0; n < 24; n++) begin
      bit_n = 24'h00_0001 << n;
      pulse(bit_n, 24'h00_0000, 24'h00_0000);
      tick(2);
      chk({31'h0, irq}, 32'h0000_0000);
      wr_reg(RSM_OFS_MASK, {8'hFF, ~bit_n});
      tick(2);
      chk({31'h0, irq}, 32'h0000_0001);
      pulse(24'h00_0000, 24'h00_0000, bit_n);
      tick(2);
      chk({31'h0, irq}, 32'h0000_0000);
      wr_reg(RSM_OFS_MASK, 32'hFFFF_FFFF);
      pulse(24'h00_0000, bit_n, 24'h00_0000);
      tick(2);
      chk({31'h0, irq}, 32'h0000_0000);
      rd_reg(RSM_OFS_STAT, {8'h00, bit_n});
      wr_reg(RSM_OFS_MASK, 32'h0000_0000);
      tick(2);
      chk({31'h0, irq}, 32'h0000_0000);
      wr_reg(RSM_OFS_MASK, 32'hFFFF_FFFF);
    end
    $display("per counter event test done");
    // Several counters at once, in groups of bits 6..3, 23..17 and 16..7
    wr_reg(RSM_OFS_MASK, 32'h0000_0000);
    pulse(24'h00_0078, 24'h00_0000, 24'h00_0000);
    tick(2);
    chk({31'h0, irq}, 32'h0000_0001);
    rd_reg(RSM_OFS_STAT, 32'h0000_0078);
    tick(2);
    chk({31'h0, irq}, 32'h0000_0000);
    wr_reg(RSM_OFS_MASK, 32'hFFFF_FFFF);
    pulse(24'hFE_0000, 24'h00_0000, 24'h00_0000);
    tick(2);
    chk({31'h0, irq}, 32'h0000_0000);
    pulse(24'h00_0000, 24'h01_FF80, 24'h00_0000);
    tick(2);
    chk({31'h0, irq}, 32'h0000_0000);
    rd_reg(RSM_OFS_STAT, 32'h00FF_FF80);
    $display("grouped event test done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
